// ### core/fwp_pkg.sv
// package: flag word layout, timing constants and carrier types
package fwp_pkg;

  // flag word field positions
  localparam int FLAG_W          = 24;
  localparam int OUT0_BIT        = 0;
  localparam int OUT1_BIT        = 1;
  localparam int OUT2_BIT        = 2;
  localparam int OUT3_BIT        = 3;
  localparam int AMP_LSB         = 4;
  localparam int AMP_W           = 2;
  localparam int SHAPE_LSB       = 6;
  localparam int SHAPE_W         = 3;
  localparam int PHZERO_BIT      = 9;
  localparam int OUT4_BIT        = 10;
  localparam int FREQ_LSB        = 11;
  localparam int FREQ_W          = 4;
  localparam int GATE_BIT        = 15;
  localparam int PHASE_LSB       = 16;
  localparam int PHASE_W         = 4;
  localparam int HIOUT_LSB       = 20;
  localparam int HIOUT_W         = 4;
  localparam int HWSEL_W         = 3;

  // reset values
  localparam logic [FLAG_W-1:0] FLAG_RST = 24'h000000;

  // timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int SYNC_HZ         = 10_000_000;
  localparam int SYNC_DIV        = CLK_HZ / SYNC_HZ;
  localparam int START_MAX_CYC   = 2;
  localparam int RESUME_MIN_CYC  = 8;
  localparam int RESUME_CNT_W    = 4;
  localparam int SYNC_CNT_W      = 3;

  // decoded control fields of one instruction
  typedef struct packed {
    logic [FREQ_W-1:0]  freq_sel;
    logic [PHASE_W-1:0] phase_sel;
    logic               rf_gate;
    logic               phase_zero;
    logic [SHAPE_W-1:0] shape_sel;
    logic [AMP_W-1:0]   amp_sel;
  } fwp_ctrl_type;

  // program control events toward the sequencer
  typedef struct packed {
    logic start;
    logic resume;
    logic restart;
  } fwp_event_type;

endpackage : fwp_pkg

// ### core/fwp_sync2.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module fwp_sync2 #(
  parameter int               W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : fwp_sync2

`default_nettype wire

// ### core/fwp_flag_pins.sv
// flag word mapping, hardware trigger/restart inputs, frequency select pins, sync clock
`timescale 1ns/1ps
`default_nettype none

module fwp_flag_pins #(
  parameter bit EXT_MOD = 1'b1
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [fwp_pkg::FLAG_W-1:0]    flag_word,
  input  wire logic                          prog_running,
  input  wire logic                          prog_waiting,
  input  wire logic                          sw_trigger,
  input  wire logic                          sw_restart,
  input  wire logic                          ext_start_strobe,
  input  wire logic                          ext_program_restart,
  input  wire logic [fwp_pkg::HWSEL_W-1:0]   ext_freq_sel,
  output fwp_pkg::fwp_ctrl_type              ctrl,
  output fwp_pkg::fwp_event_type             prog_event,
  output logic                               analog_zero,
  output logic                               phase_hold,
  output logic [8:0]                         digital_out,
  output logic                               coax_output_a,
  output logic                               coax_output_b,
  output logic [fwp_pkg::PHASE_W-1:0]        control_pin_header,
  output logic                               sync_clk_out
);

  logic [1:0]                  rst_sync_reg;
  logic                        rst_int_b;
  logic                        trig_s;
  logic                        rstin_s;
  logic [fwp_pkg::HWSEL_W-1:0] sel_s;
  logic                        trig_prev_reg;
  logic                        rstin_prev_reg;
  logic                        trig_fall;
  logic                        rstin_fall;
  logic                        any_trig;
  logic                        resume_pend_reg;
  logic [fwp_pkg::RESUME_CNT_W-1:0] resume_cnt_reg;
  logic [fwp_pkg::SYNC_CNT_W-1:0]   sync_cnt_reg;
  logic                        sync_reg;
  logic [fwp_pkg::FLAG_W-1:0]  f;
  logic [fwp_pkg::FREQ_W-1:0]  sw_freq;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync_reg[1];

  // input synchronisers
  // idle-high pins reset to one so no false edge after reset
  fwp_sync2 #(
    .W    (2),
    .INIT (2'h3)
  ) u_sync_ctl (
    .clk   (clk),
    .rst_b (rst_int_b),
    .d     ({ext_start_strobe, ext_program_restart}),
    .q     ({trig_s, rstin_s})
  );

  fwp_sync2 #(
    .W    (fwp_pkg::HWSEL_W),
    .INIT (3'h0)
  ) u_sync_sel (
    .clk   (clk),
    .rst_b (rst_int_b),
    .d     (ext_freq_sel),
    .q     (sel_s)
  );

  // falling edge detection on synchronised levels
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      trig_prev_reg  <= 1'b1;
      rstin_prev_reg <= 1'b1;
    end else begin
      trig_prev_reg  <= trig_s;
      rstin_prev_reg <= rstin_s;
    end
  end
  assign trig_fall  = trig_prev_reg & ~trig_s;
  assign rstin_fall = rstin_prev_reg & ~rstin_s;

  assign any_trig = trig_fall | sw_trigger;

  // resume delay counter for a program paused in wait
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      resume_pend_reg <= 1'b0;
      resume_cnt_reg  <= 4'h0;
    end else if (rstin_fall || sw_restart) begin
      resume_pend_reg <= 1'b0;
      resume_cnt_reg  <= 4'h0;
    end else if (any_trig && prog_waiting && !resume_pend_reg) begin
      resume_pend_reg <= 1'b1;
      resume_cnt_reg  <= 4'h1;
    end else if (resume_pend_reg) begin
      if (resume_cnt_reg == 4'(fwp_pkg::RESUME_MIN_CYC - 1)) begin
        resume_pend_reg <= 1'b0;
        resume_cnt_reg  <= 4'h0;
      end else begin
        resume_cnt_reg <= resume_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      prog_event <= '0;
    end else begin
      // restart on falling edge of restart pin
      prog_event.restart <= rstin_fall | sw_restart;
      // start one cycle after the detected edge
      prog_event.start   <= any_trig & ~prog_running & ~prog_waiting
                            & ~rstin_fall & ~sw_restart;
      prog_event.resume  <= resume_pend_reg
                            & (resume_cnt_reg == 4'(fwp_pkg::RESUME_MIN_CYC - 1));
    end
  end

  // divide master clock by five for the sync output
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      sync_cnt_reg <= 3'h0;
    end else if (sync_cnt_reg == 3'(fwp_pkg::SYNC_DIV - 1)) begin
      sync_cnt_reg <= 3'h0;
    end else begin
      sync_cnt_reg <= sync_cnt_reg + 3'h1;
    end
  end
  // odd divide: high for two of five rising edges plus a falling-edge stretch
  always_ff @(negedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      sync_reg <= 1'b0;
    end else begin
      sync_reg <= (sync_cnt_reg == 3'h1);
    end
  end
  // 50% duty square from both edges
  assign sync_clk_out = (sync_cnt_reg < 3'h2) | sync_reg;

  // flag word alias
  assign f = flag_word;

  // software field must be zero for pin selection; pins low for software
  assign sw_freq = f[fwp_pkg::FREQ_LSB +: fwp_pkg::FREQ_W];

  // registered decode of the flag word, held for the instruction
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      ctrl <= '0;
    end else begin
      // binary pin index merged with software field
      if (EXT_MOD) begin
        ctrl.freq_sel <= sw_freq | {1'b0, sel_s};
      end else begin
        ctrl.freq_sel <= sw_freq;
      end
      ctrl.phase_sel  <= f[fwp_pkg::PHASE_LSB +: fwp_pkg::PHASE_W];
      ctrl.rf_gate    <= f[fwp_pkg::GATE_BIT];
      ctrl.phase_zero <= f[fwp_pkg::PHZERO_BIT];
      ctrl.shape_sel  <= f[fwp_pkg::SHAPE_LSB +: fwp_pkg::SHAPE_W];
      ctrl.amp_sel    <= f[fwp_pkg::AMP_LSB +: fwp_pkg::AMP_W];
    end
  end

  // registered pin outputs
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      digital_out        <= 9'h000;
      coax_output_a      <= 1'b0;
      coax_output_b      <= 1'b0;
      control_pin_header <= 4'h0;
      analog_zero        <= 1'b1;
      phase_hold         <= 1'b0;
    end else begin
      digital_out[0]     <= f[fwp_pkg::OUT0_BIT];
      coax_output_a      <= f[fwp_pkg::OUT0_BIT];
      digital_out[1]     <= f[fwp_pkg::OUT1_BIT];
      coax_output_b      <= f[fwp_pkg::OUT1_BIT];
      // outputs 2, 3, 4 and 5-8
      digital_out[2]     <= f[fwp_pkg::OUT2_BIT];
      digital_out[3]     <= f[fwp_pkg::OUT3_BIT];
      digital_out[4]     <= f[fwp_pkg::OUT4_BIT];
      digital_out[8:5]   <= f[fwp_pkg::HIOUT_LSB +: fwp_pkg::HIOUT_W];
      control_pin_header <= f[fwp_pkg::PHASE_LSB +: fwp_pkg::PHASE_W];
      analog_zero        <= ~f[fwp_pkg::GATE_BIT];
      phase_hold         <= f[fwp_pkg::PHZERO_BIT];
    end
  end

  // assertions
  a_trig_start_lat: assert property (@(posedge clk) disable iff (!rst_int_b)
    (trig_fall && !prog_running && !prog_waiting && !rstin_fall && !sw_restart)
      |=> prog_event.start)
    else $error("start not raised after trigger edge");

  a_restart_edge: assert property (@(posedge clk) disable iff (!rst_int_b)
    rstin_fall |=> prog_event.restart)
    else $error("restart edge not acted on");

  // resume never earlier than eight cycles, even when a restart cuts it short
  a_resume_min_gap: assert property (@(posedge clk) disable iff (!rst_int_b)
    (any_trig && prog_waiting && !resume_pend_reg && !rstin_fall && !sw_restart)
      |=> (!prog_event.resume)[*7])
    else $error("resume came too early");

  // resume arrives on the eighth cycle unless a restart intervenes
  a_resume_arrive: assert property (@(posedge clk) disable iff (!rst_int_b)
    (any_trig && prog_waiting && !resume_pend_reg && !rstin_fall && !sw_restart)
      ##1 (!rstin_fall && !sw_restart)[*7] |=> prog_event.resume)
    else $error("resume not after eight cycles");

  a_fall_detect: assert property (@(posedge clk) disable iff (!rst_int_b)
    trig_fall |-> ($past(trig_s) && !trig_s))
    else $error("trigger edge without falling input");

  a_sync_period: assert property (@(posedge clk) disable iff (!rst_int_b)
    (sync_cnt_reg == 3'h0) |=> ##4 (sync_cnt_reg == 3'h0))
    else $error("sync divider period wrong");

  a_coax_follow: assert property (@(posedge clk) disable iff (!rst_int_b)
    ##1 (coax_output_a == $past(f[0]) && digital_out[0] == coax_output_a))
    else $error("coax a does not follow bit 0");

  a_coax_b_follow: assert property (@(posedge clk) disable iff (!rst_int_b)
    ##1 (coax_output_b == $past(f[1])))
    else $error("coax b does not follow bit 1");

  a_phase_header: assert property (@(posedge clk) disable iff (!rst_int_b)
    ##1 (control_pin_header == $past(f[19:16]) && ctrl.phase_sel == control_pin_header))
    else $error("phase header mismatch");

  a_gate_zero: assert property (@(posedge clk) disable iff (!rst_int_b)
    ##1 (analog_zero == !$past(f[15]) && analog_zero == !ctrl.rf_gate))
    else $error("analog zero not tied to gate");

  a_phase_hold: assert property (@(posedge clk) disable iff (!rst_int_b)
    ##1 (phase_hold == $past(f[9])))
    else $error("phase hold not following bit");

  a_hw_sel_decode: assert property (@(posedge clk) disable iff (!rst_int_b)
    (EXT_MOD && f[14:11] == 4'h0) |=> (ctrl.freq_sel == {1'b0, $past(sel_s)}))
    else $error("select pins decoded wrong");

  // pins at rest leave the software field in charge
  a_sel_soft: assert property (@(posedge clk) disable iff (!rst_int_b)
    (sel_s == 3'h0) |=> (ctrl.freq_sel == $past(f[14:11])))
    else $error("software frequency field not passed");

  // output pins follow their flag bits
  a_digout_map: assert property (@(posedge clk) disable iff (!rst_int_b)
    ##1 (digital_out == {$past(f[23:20]), $past(f[10]), $past(f[3:0])}))
    else $error("digital outputs do not follow flag word");

  // program events
  a_start_blocked: assert property (@(posedge clk) disable iff (!rst_int_b)
    (prog_running || prog_waiting) |=> !prog_event.start)
    else $error("start raised while program active");

  a_restart_sw: assert property (@(posedge clk) disable iff (!rst_int_b)
    sw_restart |=> (prog_event.restart && !prog_event.start))
    else $error("software restart not acted on");

  // sync output rises once every five clocks
  a_sync_rise: assert property (@(posedge clk) disable iff (!rst_int_b)
    $rose(sync_clk_out) |=> ##4 $rose(sync_clk_out))
    else $error("sync output period wrong");

endmodule : fwp_flag_pins

`default_nettype wire

// ### test/fwp_pin_driver.sv
// partner model: lab hardware pulling trigger, restart and select pins
`timescale 1ns/1ps
`default_nettype none

module fwp_pin_driver #(
  parameter int LOW_CYC = 3
) (
  input  wire logic       clk,
  input  wire logic       trig_req,
  input  wire logic       rst_req,
  input  wire logic       sel_drive,
  input  wire logic [2:0] sel_val,
  input  wire logic       field_zero,
  output logic            ext_start_strobe,
  output logic            ext_program_restart,
  output logic [2:0]      ext_freq_sel
);
  int trig_cnt_reg;
  int rst_cnt_reg;

  // low-time counters, each pull lasts LOW_CYC cycles
  always_ff @(posedge clk) begin
    trig_cnt_reg <= trig_req ? LOW_CYC - 1 : (trig_cnt_reg > 0 ? trig_cnt_reg - 1 : 0);
    rst_cnt_reg  <= rst_req ? LOW_CYC - 1 : (rst_cnt_reg > 0 ? rst_cnt_reg - 1 : 0);
  end

  assign ext_start_strobe    = !(trig_req || trig_cnt_reg > 0);
  assign ext_program_restart = !(rst_req || rst_cnt_reg > 0);
  // pins driven only with field zero
  assign ext_freq_sel = (sel_drive && field_zero) ? sel_val : 3'h0;
endmodule : fwp_pin_driver
`default_nettype wire

// ### test/fwp_flag_pins_bench.sv
// self-checking bench for flag mapping, pin events and sync output
`timescale 1ns/1ps
`default_nettype none

module fwp_flag_pins_bench;
  logic                  clk;
  logic                  rst_b;
  logic [23:0]           flag_word;
  logic                  prog_running;
  logic                  prog_waiting;
  logic                  sw_trigger;
  logic                  sw_restart;
  logic                  trig_req;
  logic                  rst_req;
  logic                  sel_drive;
  logic [2:0]            sel_val;
  logic                  ext_start_strobe;
  logic                  ext_program_restart;
  logic [2:0]            ext_freq_sel;
  fwp_pkg::fwp_ctrl_type  ctrl;
  fwp_pkg::fwp_event_type prog_event;
  logic                  analog_zero;
  logic                  phase_hold;
  logic [8:0]            digital_out;
  logic                  coax_output_a;
  logic                  coax_output_b;
  logic [3:0]            control_pin_header;
  logic                  sync_clk_out;
  int                    bad_count;
  int                    checks_done;
  logic [31:0]           seed;

  fwp_flag_pins #(.EXT_MOD(1'b1)) dut (.clk(clk), .rst_b(rst_b), .flag_word(flag_word),
    .prog_running(prog_running), .prog_waiting(prog_waiting), .sw_trigger(sw_trigger),
    .sw_restart(sw_restart), .ext_start_strobe(ext_start_strobe),
    .ext_program_restart(ext_program_restart), .ext_freq_sel(ext_freq_sel), .ctrl(ctrl),
    .prog_event(prog_event), .analog_zero(analog_zero), .phase_hold(phase_hold),
    .digital_out(digital_out), .coax_output_a(coax_output_a), .coax_output_b(coax_output_b),
    .control_pin_header(control_pin_header), .sync_clk_out(sync_clk_out));

  fwp_pin_driver partner (.clk(clk), .trig_req(trig_req), .rst_req(rst_req),
    .sel_drive(sel_drive), .sel_val(sel_val), .field_zero(flag_word[14:11] == 4'h0),
    .ext_start_strobe(ext_start_strobe), .ext_program_restart(ext_program_restart),
    .ext_freq_sel(ext_freq_sel));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic summarize();
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  // apply one flag word, check pin outputs next cycle and ctrl five cycles later
  task automatic flag_step(input logic [23:0] f);
    int ef;
    @(posedge clk);
    flag_word <= f;
    @(posedge clk);
    #1;
    check(digital_out, {f[23:20], f[10], f[3:0]});
    check({coax_output_b, coax_output_a}, f[1:0]);
    check(control_pin_header, f[19:16]);
    check(analog_zero, {~f[15]});
    check(phase_hold, f[9]);
    ef = f[14:11];
    if (ef == 0 && sel_drive) ef = sel_val;
    repeat (4) @(posedge clk);
    #1;
    check(ctrl, {ef[3:0], f[19:16], f[15], f[9], f[8:6], f[5:4]});
  endtask : flag_step

  // request one event, measure edges until its pulse (16 = none)
  task automatic fire(input int src, input int exp_lat, input int bitn);
    int lat;
    @(posedge clk);
    case (src)
      0: sw_trigger <= 1'b1;
      1: sw_restart <= 1'b1;
      2: trig_req <= 1'b1;
      default: rst_req <= 1'b1;
    endcase
    lat = 0;
    while (lat < 16) begin
      @(posedge clk);
      sw_trigger <= 1'b0;
      sw_restart <= 1'b0;
      trig_req   <= 1'b0;
      rst_req    <= 1'b0;
      lat++;
      #1;
      if (prog_event[bitn] === 1'b1) break;
    end
    check(lat, exp_lat);
    if (lat == 16 && exp_lat != 16) summarize();
    repeat (6) @(posedge clk);
  endtask : fire

  initial begin
    int hi;
    int rises;
    logic prev;
    bad_count = 0;
    checks_done = 0;
    seed = 32'h64213E9E;
    rst_b = 1'b0;
    flag_word = 24'h000000;
    prog_running = 1'b0;
    prog_waiting = 1'b0;
    sw_trigger = 1'b0;
    sw_restart = 1'b0;
    trig_req = 1'b0;
    rst_req = 1'b0;
    sel_drive = 1'b0;
    sel_val = 3'h0;
    repeat (3) @(posedge clk);
    #1;
    check({analog_zero, digital_out, prog_event}, 32'h1000);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    // idle start and restart from software and pin, then start blocked while running
    fire(0, 1, 2);
    fire(2, 3, 2);
    fire(1, 1, 0);
    fire(3, 3, 0);
    prog_running <= 1'b1;
    fire(0, 16, 2);
    fire(2, 16, 2);
    prog_running <= 1'b0;
    prog_waiting <= 1'b1;
    // resume takes eight cycles after a software trigger, ten after a pin pull
    fire(0, 8, 1);
    fire(2, 10, 1);
    @(posedge clk);
    sw_trigger <= 1'b1;
    @(posedge clk);
    sw_trigger <= 1'b0;
    @(posedge clk);
    sw_restart <= 1'b1;
    @(posedge clk);
    sw_restart <= 1'b0;
    hi = 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (prog_event.resume === 1'b1) hi++;
    end
    check(hi, 0);
    prog_waiting <= 1'b0;
    // every select pin code with field zero
    sel_drive <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      sel_val <= i[2:0];
      flag_step(24'h000000);
    end
    // random flag words, pins driven or floating
    repeat (24) begin
      seed = xs(seed);
      sel_drive <= seed[31];
      sel_val <= seed[30:28];
      flag_step(seed[23:0]);
    end
    @(clk);
    #5;
    prev = sync_clk_out;
    hi = 0;
    rises = 0;
    repeat (40) begin
      @(clk);
      #5;
      if (sync_clk_out === 1'b1) hi++;
      if (sync_clk_out === 1'b1 && prev === 1'b0) rises++;
      prev = sync_clk_out;
    end
    check(hi, 20);
    check(rises, 4);
    summarize();
  end
endmodule : fwp_flag_pins_bench
`default_nettype wire
